// file: pllsw_out_div.sv
// Package of shared constants and one output divider with duty, phase tap and start delay.
`default_nettype none

package pllsw_pkg;
   // Clock of the control logic.
   localparam int CLK_PERIOD_NS = 100;
   // Nominal reference period; the static-input limit is derived from it.
   localparam int REF_PERIOD_NS = 400;
   localparam int REF_PERIOD_CLKS = (REF_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STATIC_REF_CYCLES = 2;
   localparam int STATIC_LIMIT = STATIC_REF_CYCLES * REF_PERIOD_CLKS;
   localparam int IDLE_W = 8;
   localparam logic [IDLE_W-1:0] IDLE_MAX = 8'hff;
   localparam logic [IDLE_W-1:0] IDLE_LIMIT = IDLE_W'(STATIC_LIMIT);
   // Rising edges of the active reference that the request must stay high for.
   localparam logic [1:0] REQ_MIN_EDGES = 2'h3;
   // Active reference edges after which the loop counts as locked again.
   localparam logic [3:0] LOCK_EDGES = 4'h8;
   // Allowed frequency spread between the two references, in percent.
   localparam logic [15:0] FREQ_TOL_PCT = 16'h0014;
   localparam logic [15:0] PCT_FULL = 16'h0064;
   // Mode codes on the mode input.
   localparam logic [1:0] MODE_AUTO = 2'h0;
   localparam logic [1:0] MODE_MANUAL = 2'h1;
   localparam logic [1:0] MODE_AUTO_OVR = 2'h2;
   // Divider layout: eight phase taps, eight-bit counts, output counter and feedback.
   localparam int TAP_W = 3;
   localparam int DIV_W = 8;
   localparam int DUTY_W = 10;
   localparam int NUM_DIV = 2;
   localparam logic [DUTY_W-1:0] DUTY_HALF_PM = 10'h1f4;
endpackage

module pllsw_out_div
   import pllsw_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic pll_reset_i,
   input wire logic [DIV_W-1:0] high_i,
   input wire logic [DIV_W-1:0] low_i,
   input wire logic [DIV_W-1:0] start_i,
   input wire logic [TAP_W-1:0] tap_init_i,
   input wire logic step_i,
   input wire logic step_up_i,
   output logic div_clk_o,
   output logic [TAP_W-1:0] tap_o,
   output logic [DUTY_W-1:0] duty_step_o
);
   typedef enum logic [1:0] {DIV_DELAY, DIV_HIGH, DIV_LOW} pllsw_div_t;

   pllsw_div_t state_r;
   logic [DIV_W-1:0] cnt_r;

   // Duty step in per-mille: half a period over the division value.
   function automatic logic [DUTY_W-1:0] duty_step(input logic [DIV_W-1:0] hi,
                                                   input logic [DIV_W-1:0] lo);
      logic [DUTY_W-1:0] div;
      div = {2'h0, hi} + {2'h0, lo};
      if (div == 10'h000) begin
         duty_step = DUTY_HALF_PM;
      end else begin
         duty_step = DUTY_HALF_PM / div;
      end
   endfunction

   // Start delay, then alternating high and low counts of VCO cycles.
   always_ff @(posedge clk_i) begin
      if (reset_i || pll_reset_i) begin
         state_r <= DIV_DELAY;
         cnt_r <= 8'h00;
         div_clk_o <= 1'b0;
      end else begin
         case (state_r)
            DIV_DELAY: begin
               // A start value of 0 or 1 means no coarse shift.
               // Counting 0 up to C-1 holds the start back by C-1 cycles against C of one.
               if (start_i <= 8'h01 || cnt_r == start_i - 8'h01) begin
                  state_r <= DIV_HIGH;
                  cnt_r <= 8'h00;
                  div_clk_o <= 1'b1;
               end else begin
                  cnt_r <= cnt_r + 8'h01;
               end
            end
            DIV_HIGH: begin
               if (cnt_r + 8'h01 >= high_i) begin
                  state_r <= DIV_LOW;
                  cnt_r <= 8'h00;
                  div_clk_o <= 1'b0;
               end else begin
                  cnt_r <= cnt_r + 8'h01;
               end
            end
            DIV_LOW: begin
               if (cnt_r + 8'h01 >= low_i) begin
                  state_r <= DIV_HIGH;
                  cnt_r <= 8'h00;
                  div_clk_o <= 1'b1;
               end else begin
                  cnt_r <= cnt_r + 8'h01;
               end
            end
            default: begin
               state_r <= DIV_DELAY;
               cnt_r <= 8'h00;
               div_clk_o <= 1'b0;
            end
         endcase
      end
   end

   // Phase tap: loaded on PLL reset, then stepped one tap per shift pulse, wrapping.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         tap_o <= 3'h0;
      end else if (pll_reset_i) begin
         tap_o <= tap_init_i;
      end else if (step_i) begin
         tap_o <= step_up_i ? tap_o + 3'h1 : tap_o - 3'h1;
      end
   end

   // Reported duty resolution follows the programmed counts.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         duty_step_o <= 10'h000;
      end else begin
         duty_step_o <= duty_step(high_i, low_i);
      end
   end

   a_coarse_none: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_r == DIV_DELAY && start_i <= 8'h01 && !pll_reset_i) |=> state_r == DIV_HIGH)
      else $error("Start value of one still delayed the counter.");
   a_tap_step_up: assert property (@(posedge clk_i) disable iff (reset_i)
      (step_i && step_up_i && !pll_reset_i) |=> tap_o == $past(tap_o) + 3'h1)
      else $error("Phase tap did not advance by one step.");
   a_high_time: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_r == DIV_HIGH && high_i == 8'h02 && low_i == 8'h02 && cnt_r == 8'h00
       && !pll_reset_i ##1 !pll_reset_i && $stable(high_i)) |=> !div_clk_o)
      else $error("High time of two VCO cycles was not kept.");
endmodule

`default_nettype wire

// file: pllsw_switchover.sv
// Reference switchover with clock sense, glitch-free mux, lock tracking and output dividers.
// Operation
// - Auto mode: switch away from stopped input.
// - Manual: rising request held three edges swaps.
// - Override: high request blocks automatic switching.
// - Drive two fail flags and select indicator.
// - Fail flag rises when its input stops.
// - Over 20% spread: only indicator valid.
// - Indicator shows which input feeds PLL.
// - Auto switching repeats in both directions.
// - State machine drives internal mux select.
// - Both inputs dead: no switch, flags invalid.
// - Duty from separate high and low counts.
// - Duty step is 50% over division.
// - Counters pick one of eight phase taps.
// - Coarse shift delays start by C-1.
// - Runtime shift steps taps, one shift clock.
// - PLL reset clears counters, outputs and lock.
// - Primary input selected by default.
// - Fail after about two static reference cycles.
// - Only request rising edge switches.
`default_nettype none

module pllsw_switchover
   import pllsw_pkg::*;
(
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic primary_ref_in_i,
   input wire logic backup_ref_in_i,
   input wire logic switch_request_i,
   input wire logic [1:0] mode_i,
   input wire logic pll_async_reset_i,
   input wire logic reconfig_shift_clock_i,
   input wire logic shift_sel_i,
   input wire logic shift_up_i,
   input wire logic [NUM_DIV*DIV_W-1:0] div_high_i,
   input wire logic [NUM_DIV*DIV_W-1:0] div_low_i,
   input wire logic [NUM_DIV*DIV_W-1:0] div_start_i,
   input wire logic [NUM_DIV*TAP_W-1:0] div_tap_i,
   output logic [1:0] input_fail_flag_o,
   output logic selected_input_indicator_o,
   output logic mux_select_internal_o,
   output logic ref_mux_out_o,
   output logic flags_valid_o,
   output logic pll_locked_o,
   output logic [NUM_DIV-1:0] div_clk_o,
   output logic [NUM_DIV*TAP_W-1:0] div_tap_o,
   output logic [NUM_DIV*DUTY_W-1:0] div_duty_step_o
);
   typedef enum logic [1:0] {SW_IDLE, SW_GATE_OLD, SW_WAIT_NEW} pllsw_state_t;

   pllsw_state_t state_r;
   logic [3:0] sync1_r, sync2_r, sync3_r;
   logic [IDLE_W-1:0] idle_cnt_r [2];
   logic [IDLE_W-1:0] per_cnt_r [2];
   logic [IDLE_W-1:0] period_r [2];
   logic sel_r, gate_en_r, armed_r, pending_r;
   logic [1:0] req_cnt_r;
   logic [3:0] lock_cnt_r;
   logic [1:0] rise, fall, dead;
   logic act_rise, req_rise, shift_rise, manual_go, auto_go, auto_allowed;
   logic old_fall, new_fall, new_dead;

   // Spread check: the difference of periods against the tolerance of the longer one.
   function automatic logic within_tol(input logic [IDLE_W-1:0] a, input logic [IDLE_W-1:0] b);
      logic [15:0] hi, lo;
      hi = (a > b) ? {8'h00, a} : {8'h00, b};
      lo = (a > b) ? {8'h00, b} : {8'h00, a};
      // One cycle of sampling error is forgiven: a nominal period is only a few cycles
      // long, so that error alone would exceed the tolerance and make the flag flicker.
      within_tol = (hi - lo <= 16'h0001) || (((hi - lo) * PCT_FULL) <= (hi * FREQ_TOL_PCT));
   endfunction

   // Modes in which the request input may start a switchover; code 3 never switches.
   function automatic logic req_mode(input logic [1:0] m);
      req_mode = (m == MODE_MANUAL) || (m == MODE_AUTO_OVR);
   endfunction

   // Bits: 0 primary, 1 backup, 2 request, 3 shift clock; all arrive from pins.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         sync1_r <= 4'h0;
         sync2_r <= 4'h0;
         sync3_r <= 4'h0;
      end else begin
         sync1_r <= {reconfig_shift_clock_i, switch_request_i, backup_ref_in_i,
                     primary_ref_in_i};
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   // Edge detection only looks at the second and third stages.
   always_comb begin
      rise = sync2_r[1:0] & ~sync3_r[1:0];
      fall = ~sync2_r[1:0] & sync3_r[1:0];
      dead = input_fail_flag_o;
      act_rise = sel_r ? rise[1] : rise[0];
      req_rise = sync2_r[2] & ~sync3_r[2];
      shift_rise = sync2_r[3] & ~sync3_r[3];
      old_fall = sel_r ? fall[1] : fall[0];
      new_fall = sel_r ? fall[0] : fall[1];
      new_dead = sel_r ? dead[0] : dead[1];
      auto_allowed = (mode_i == MODE_AUTO) || (mode_i == MODE_AUTO_OVR && !sync2_r[2]);
      auto_go = auto_allowed && (sel_r ? dead[1] : dead[0]) && !new_dead;
      manual_go = armed_r && sync2_r[2] && act_rise && req_cnt_r == REQ_MIN_EDGES - 2'h1;
   end

   // Clock sense: idle time and period of each input in control clock cycles.
   always_ff @(posedge clk_i) begin
      for (int i = 0; i < 2; i++) begin
         if (reset_i) begin
            idle_cnt_r[i] <= 8'h00;
            per_cnt_r[i] <= 8'h00;
            period_r[i] <= 8'h00;
            input_fail_flag_o[i] <= 1'b0;
         end else begin
            idle_cnt_r[i] <= (rise[i] || fall[i]) ? 8'h00 :
                             (idle_cnt_r[i] == IDLE_MAX) ? IDLE_MAX : idle_cnt_r[i] + 8'h01;
            per_cnt_r[i] <= rise[i] ? 8'h00 :
                            (per_cnt_r[i] == IDLE_MAX) ? IDLE_MAX : per_cnt_r[i] + 8'h01;
            if (rise[i]) begin
               period_r[i] <= per_cnt_r[i];
            end
            input_fail_flag_o[i] <= idle_cnt_r[i] >= IDLE_LIMIT;
         end
      end
   end

   // Flags are trusted only while one input lives and the periods agree.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         flags_valid_o <= 1'b0;
      end else begin
         flags_valid_o <= !(dead[0] && dead[1]) && within_tol(period_r[0], period_r[1]);
      end
   end

   // Request qualification counts rising edges of the active reference while held.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         armed_r <= 1'b0;
         req_cnt_r <= 2'h0;
      end else if (req_rise) begin
         armed_r <= 1'b1;
         req_cnt_r <= 2'h0;
      end else if (!sync2_r[2] || manual_go) begin
         armed_r <= 1'b0;
         req_cnt_r <= 2'h0;
      end else if (armed_r && act_rise) begin
         req_cnt_r <= req_cnt_r + 2'h1;
      end
   end

   // A qualified request waits here until the state machine picks it up; the set wins.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         pending_r <= 1'b0;
      end else if (manual_go && req_mode(mode_i)) begin
         pending_r <= 1'b1;
      end else if (state_r != SW_IDLE || !req_mode(mode_i)) begin
         pending_r <= 1'b0;
      end
   end

   // Switchover sequence: gate the old input on its fall, enable the new on its fall.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         state_r <= SW_IDLE;
         sel_r <= 1'b0;
         gate_en_r <= 1'b1;
      end else begin
         case (state_r)
            SW_IDLE: begin
               if (pending_r || auto_go) begin
                  state_r <= SW_GATE_OLD;
               end
            end
            SW_GATE_OLD: begin
               // A stopped input has no fall left, so it is gated at once.
               if (old_fall || (sel_r ? dead[1] : dead[0])) begin
                  gate_en_r <= 1'b0;
                  state_r <= SW_WAIT_NEW;
               end
            end
            SW_WAIT_NEW: begin
               // Waits without limit for a live target; the mux stays gated meanwhile.
               if (new_fall && !new_dead) begin
                  sel_r <= ~sel_r;
                  gate_en_r <= 1'b1;
                  state_r <= SW_IDLE;
               end
            end
            default: begin
               state_r <= SW_IDLE;
               gate_en_r <= 1'b1;
            end
         endcase
      end
   end

   // Registered status and the gated reference seen by the loop.
   always_ff @(posedge clk_i) begin
      if (reset_i) begin
         mux_select_internal_o <= 1'b0;
         selected_input_indicator_o <= 1'b0;
         ref_mux_out_o <= 1'b0;
      end else begin
         mux_select_internal_o <= sel_r;
         selected_input_indicator_o <= sel_r;
         ref_mux_out_o <= gate_en_r && (sel_r ? sync2_r[1] : sync2_r[0]);
      end
   end

   // Lock drops on PLL reset or any switchover; the partner is expected to reset after it.
   always_ff @(posedge clk_i) begin
      if (reset_i || pll_async_reset_i || state_r != SW_IDLE) begin
         lock_cnt_r <= 4'h0;
         pll_locked_o <= 1'b0;
      end else begin
         if (act_rise && lock_cnt_r != LOCK_EDGES) begin
            lock_cnt_r <= lock_cnt_r + 4'h1;
         end
         pll_locked_o <= lock_cnt_r == LOCK_EDGES;
      end
   end

   // Output counter and feedback divider; a shift clock edge steps the chosen one.
   for (genvar g = 0; g < NUM_DIV; g++) begin : g_div
      pllsw_out_div u_div (
         .clk_i(clk_i),
         .reset_i(reset_i),
         .pll_reset_i(pll_async_reset_i),
         .high_i(div_high_i[g*DIV_W +: DIV_W]),
         .low_i(div_low_i[g*DIV_W +: DIV_W]),
         .start_i(div_start_i[g*DIV_W +: DIV_W]),
         .tap_init_i(div_tap_i[g*TAP_W +: TAP_W]),
         .step_i(shift_rise && (shift_sel_i == 1'(g))),
         .step_up_i(shift_up_i),
         .div_clk_o(div_clk_o[g]),
         .tap_o(div_tap_o[g*TAP_W +: TAP_W]),
         .duty_step_o(div_duty_step_o[g*DUTY_W +: DUTY_W])
      );
   end

   a_fail_static: assert property (@(posedge clk_i) disable iff (reset_i)
      (idle_cnt_r[0] >= IDLE_LIMIT) |=> input_fail_flag_o[0])
      else $error("Primary stayed static but its fail flag is low.");
   a_both_dead_hold: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_r == SW_IDLE && dead == 2'h3 && mode_i == MODE_AUTO) |=> state_r == SW_IDLE)
      else $error("Switchover started with both inputs dead.");
   a_indicator_match: assert property (@(posedge clk_i) disable iff (reset_i)
      selected_input_indicator_o == mux_select_internal_o)
      else $error("Indicator differs from mux select.");
   a_sel_gated: assert property (@(posedge clk_i) disable iff (reset_i)
      $changed(sel_r) |-> $past(!gate_en_r) && gate_en_r)
      else $error("Select changed while the mux was not gated.");
   a_override_block: assert property (@(posedge clk_i) disable iff (reset_i)
      (mode_i == MODE_AUTO_OVR && sync2_r[2] && state_r == SW_IDLE && !pending_r)
      |=> state_r == SW_IDLE)
      else $error("Automatic switch ran while the override was held.");
   a_manual_three: assert property (@(posedge clk_i) disable iff (reset_i)
      $rose(pending_r) |-> $past(armed_r && act_rise && req_cnt_r == 2'h2 && sync2_r[2]))
      else $error("Manual switch without three held reference edges.");
   a_auto_switch: assert property (@(posedge clk_i) disable iff (reset_i)
      (state_r == SW_IDLE && mode_i == MODE_AUTO && auto_go) |=> state_r == SW_GATE_OLD)
      else $error("Failed active input did not start a switchover.");
   a_lock_drop: assert property (@(posedge clk_i) disable iff (reset_i)
      pll_async_reset_i |=> !pll_locked_o ##1 (!pll_locked_o || !$past(pll_async_reset_i)))
      else $error("Lock stayed high through PLL reset.");
   a_default_primary: assert property (@(posedge clk_i)
      $fell(reset_i) |-> !sel_r && gate_en_r)
      else $error("Primary is not selected after reset.");
endmodule

`default_nettype wire

// file: pllsw_ref_model.sv
// Behavioural model of the two reference oscillators that feed the switchover block.
`default_nettype none

module pllsw_ref_model (
   input wire logic run_p_i,
   input wire logic run_b_i,
   output logic primary_ref_o,
   output logic backup_ref_o
);
   timeunit 1ns;
   timeprecision 1ps;

   // Both sources start at a known level so the sense logic never sees an unknown.
   initial begin
      primary_ref_o = 1'b0;
      backup_ref_o = 1'b0;
   end

   // A stopped oscillator freezes at its last level, as a dead crystal would.
   always begin
      #200;
      if (run_p_i) primary_ref_o = ~primary_ref_o;
   end

   // The backup runs a few percent fast, so its phase drifts against the control clock.
   always begin
      #195;
      if (run_b_i) backup_ref_o = ~backup_ref_o;
   end
endmodule

`default_nettype wire

// file: pllsw_switchover_tb_top.sv
// Self-checking bench for the reference switchover block and its output dividers.
`default_nettype none
`define CHECK(got, exp) begin checks++; if ((got) !== (exp)) begin fail_count++; \
   $display("ERROR at %0t: got %0h expected %0h", $time, (got), (exp)); end end

module pllsw_switchover_tb_top
   import pllsw_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic run_p = 1'b1;
   logic run_b = 1'b1;
   wire primary_ref;
   wire backup_ref;
   logic switch_request = 1'b0;
   logic [1:0] mode = 2'h3;
   logic pll_rst = 1'b0;
   logic shift_clk = 1'b0;
   logic shift_sel = 1'b0;
   logic shift_up = 1'b0;
   logic [15:0] div_high = 16'h0302;
   logic [15:0] div_low = 16'h0202;
   logic [15:0] div_start = 16'h0101;
   logic [5:0] div_tap = 6'h07;
   logic [1:0] fail_flag;
   logic ind;
   logic msel;
   logic mux_out;
   logic fvalid;
   logic locked;
   logic [1:0] dclk;
   logic [5:0] dtap;
   logic [19:0] dstep;
   int fail_count = 0;
   int checks = 0;

   // Control clock at 10 MHz.
   always #50 clk_i = ~clk_i;

   pllsw_ref_model u_refs (
      .run_p_i(run_p),
      .run_b_i(run_b),
      .primary_ref_o(primary_ref),
      .backup_ref_o(backup_ref)
   );

   pllsw_switchover u_dut (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .primary_ref_in_i(primary_ref),
      .backup_ref_in_i(backup_ref),
      .switch_request_i(switch_request),
      .mode_i(mode),
      .pll_async_reset_i(pll_rst),
      .reconfig_shift_clock_i(shift_clk),
      .shift_sel_i(shift_sel),
      .shift_up_i(shift_up),
      .div_high_i(div_high),
      .div_low_i(div_low),
      .div_start_i(div_start),
      .div_tap_i(div_tap),
      .input_fail_flag_o(fail_flag),
      .selected_input_indicator_o(ind),
      .mux_select_internal_o(msel),
      .ref_mux_out_o(mux_out),
      .flags_valid_o(fvalid),
      .pll_locked_o(locked),
      .div_clk_o(dclk),
      .div_tap_o(dtap),
      .div_duty_step_o(dstep)
   );

   // Prints the counts and the verdict, then ends the run.
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Bounded waits, so a stuck design shows up as a mismatch rather than a stall.
   task automatic wait_ind(input logic v, input int lim);
      int n;
      n = 0;
      while (ind !== v && n < lim) begin
         @(negedge clk_i);
         n++;
      end
      // A limit that runs out is a mismatch in its own right.
      if (ind !== v) begin
         fail_count++;
         $display("ERROR at %0t: indicator wait timed out", $time);
      end
   endtask

   task automatic wait_flag(input int i, input logic v, input int lim);
      int n;
      n = 0;
      while (fail_flag[i] !== v && n < lim) begin
         @(negedge clk_i);
         n++;
      end
      if (fail_flag[i] !== v) begin
         fail_count++;
         $display("ERROR at %0t: fail flag wait timed out", $time);
      end
   endtask

   // Pulses the loop reset with start delay c and counts cycles to the first output rise.
   task automatic pll_pulse(input logic [7:0] c, output int n);
      div_start[7:0] = c;
      pll_rst = 1'b1;
      repeat (2) @(negedge clk_i);
      `CHECK(dclk[0], 1'b0)
      `CHECK(locked, 1'b0)
      pll_rst = 1'b0;
      n = 0;
      while (dclk[0] !== 1'b1 && n < 40) begin
         @(negedge clk_i);
         n++;
      end
   endtask

   // One tap step: the pin is held long enough to survive the synchroniser.
   task automatic shift_step();
      shift_clk = 1'b1;
      repeat (3) @(negedge clk_i);
      shift_clk = 1'b0;
      repeat (5) @(negedge clk_i);
   endtask

   task automatic t_reset();
      `CHECK(ind, 1'b0)
      `CHECK(fail_flag, 2'h0)
      `CHECK(locked, 1'b0)
   endtask

   task automatic t_divider();
      int n1;
      int n3;
      `CHECK(dstep[9:0], 10'h07d)
      `CHECK(dstep[19:10], 10'h064)
      pll_pulse(8'h01, n1);
      `CHECK(dclk, 2'h3)
      `CHECK(dtap, 6'h07)
      pll_pulse(8'h03, n3);
      `CHECK(n3 - n1, 2)
      // Divider one started two cycles earlier and is still inside its three-cycle high.
      `CHECK(dclk, 2'h3)
      // Measure one high and one low phase of divider zero, set to two and two.
      n1 = 0;
      while (dclk[0] === 1'b1 && n1 < 20) begin
         @(negedge clk_i);
         n1++;
      end
      `CHECK(n1, 2)
      n1 = 0;
      while (dclk[0] === 1'b0 && n1 < 20) begin
         @(negedge clk_i);
         n1++;
      end
      `CHECK(n1, 2)
      shift_sel = 1'b0;
      shift_up = 1'b1;
      shift_step();
      `CHECK(dtap, 6'h00)
      shift_sel = 1'b1;
      shift_up = 1'b0;
      shift_step();
      `CHECK(dtap, 6'h38)
      shift_step();
      `CHECK(dtap, 6'h30)
      n1 = 0;
      while (locked !== 1'b1 && n1 < 100) begin
         @(negedge clk_i);
         n1++;
      end
      `CHECK(locked, 1'b1)
   endtask

   task automatic t_manual();
      int n;
      // Mode code 3 switches nothing, even for a request held well past three edges.
      switch_request = 1'b1;
      repeat (30) @(negedge clk_i);
      `CHECK(ind, 1'b0)
      switch_request = 1'b0;
      repeat (5) @(negedge clk_i);
      mode = MODE_MANUAL;
      switch_request = 1'b1;
      wait_ind(1'b1, 80);
      `CHECK(ind, 1'b1)
      @(negedge clk_i);
      `CHECK(msel, 1'b1)
      repeat (10) @(negedge clk_i);
      switch_request = 1'b0;
      repeat (40) @(negedge clk_i);
      `CHECK(ind, 1'b1)
      // Too short a request spans at most one active reference edge.
      switch_request = 1'b1;
      repeat (3) @(negedge clk_i);
      switch_request = 1'b0;
      repeat (40) @(negedge clk_i);
      `CHECK(ind, 1'b1)
      pll_pulse(8'h01, n);
      `CHECK(fail_flag, 2'h0)
   endtask

   task automatic t_override();
      mode = MODE_AUTO_OVR;
      switch_request = 1'b1;
      wait_ind(1'b0, 80);
      `CHECK(ind, 1'b0)
      run_p = 1'b0;
      repeat (4) @(negedge clk_i);
      `CHECK(fail_flag[0], 1'b0)
      wait_flag(0, 1'b1, 12);
      `CHECK(fail_flag[0], 1'b1)
      repeat (60) @(negedge clk_i);
      `CHECK(ind, 1'b0)
      // The mux still passes the selected, now frozen, primary level.
      `CHECK(mux_out, primary_ref)
      run_p = 1'b1;
      wait_flag(0, 1'b0, 40);
      switch_request = 1'b0;
      repeat (20) @(negedge clk_i);
   endtask

   task automatic t_auto();
      mode = MODE_AUTO;
      `CHECK(fvalid, 1'b1)
      run_p = 1'b0;
      wait_ind(1'b1, 80);
      `CHECK(ind, 1'b1)
      @(negedge clk_i);
      `CHECK(msel, 1'b1)
      `CHECK(fail_flag, 2'h1)
      run_p = 1'b1;
      wait_flag(0, 1'b0, 40);
      run_b = 1'b0;
      wait_ind(1'b0, 80);
      `CHECK(ind, 1'b0)
      run_b = 1'b1;
      wait_flag(1, 1'b0, 40);
      `CHECK(fail_flag, 2'h0)
   endtask

   task automatic t_dead();
      run_p = 1'b0;
      run_b = 1'b0;
      repeat (60) @(negedge clk_i);
      `CHECK(ind, 1'b0)
      `CHECK(fvalid, 1'b0)
      run_p = 1'b1;
      run_b = 1'b1;
   endtask

   // Main sequence: reset for four cycles, then the scenarios in turn.
   initial begin
      repeat (4) @(negedge clk_i);
      reset_i = 1'b0;
      @(negedge clk_i);
      t_reset();
      t_divider();
      t_manual();
      t_override();
      t_auto();
      t_dead();
      complete_run();
   end

   // Watchdog well beyond the thousand or so cycles the scenarios need at most.
   initial begin
      #1000000;
      fail_count++;
      complete_run();
   end
endmodule

`default_nettype wire
